// [design/ctf_core.v]
// CAN bit timing, acceptance masks and interrupt enable/pending registers
//
// Contract
// - Diagnostic enable gates listen-only, ack-ignore, loopback, internal and hidden-buffer writes.
// - Error type select 0 sets error pending on every bus error.
// - Error type select 1 sets error pending only on counter-caused node state change.
// - Prescaler divides by field plus two, saturating at 128.
// - Jump width equals field plus one quantum, 1 to 4.
// - First segment length is field plus one quanta.
// - Second segment length is field plus one quanta, 1 to 8.
// - Global mask bit 0 requires equality, 1 accepts any value.
// - Don't-care identifier bits are overwritten with received values on acceptance.
// - Extended frames use all mask bits; RTR masks SRR, ext remote masks RTR.
// - Standard frames use mask bits 28..18, RTR and IDE only.
// - Basic mask filters its buffer with the same per-bit rule.
// - Basic mask uses the same extended and standard bit mapping.
// - Basic mask upper holds m28..18, rtr, ide, m17..15; lower m14..0, ext_remote_mask.
// - Enable register: bit 15 error enable, bits 14..0 buffer enables.
// - Error interrupt produced only while error enable is one.
// - Pending bit n set after successful transfer through buffer n.
// - Error pending bit 15 records a bus error (type select 0) or status change (type select 1) and raises enabled interrupt.
// - Writing one to clear bit 15 clears error pending; zero leaves it.
// - Node state encodes idle 000, active 010, warning 011, passive 10X, bus off 11X.
`include "ctf_map.vh"

module ctf_core
#(
	parameter NBUF = 15
)
(
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        ce_i,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output wire        wb_ack_o,
	output wire        wb_err_o,
	// Frame engine side
	input  wire        bus_error_i,
	input  wire [2:0]  node_state_field_i,
	input  wire        cnt_incr_i,
	input  wire [NBUF-1:0] buf_done_i,
	input  wire [28:0] rx_id_i,
	input  wire        rx_ide_i,
	input  wire        rx_srr_i,
	input  wire        rx_rtr_i,
	input  wire [28:0] buf_id_i,
	input  wire        buf_ide_i,
	input  wire        buf_srr_i,
	input  wire        buf_rtr_i,
	input  wire        rx_resync_i,
	// Filter results
	output reg         global_accept_o,
	output reg         basic_accept_o,
	output reg  [28:0] global_store_id_o,
	output reg  [28:0] basic_store_id_o,
	// Diagnostic modes
	output reg         listen_only_sel_o,
	output reg         ack_ignore_sel_o,
	output reg         loopback_sel_o,
	output reg         internal_sel_o,
	output reg         hidden_wr_en_o,
	// Bit timing
	output reg         tq_tick_o,
	output reg         sample_point_o,
	output reg  [2:0]  resync_jump_width_o,
	// Interrupt request level
	output reg         irq_o
);

	// Registers
	reg [6:0]  config_reg;
	reg [15:0] bit_timing_config_reg;
	reg [15:0] global_mask_upper_reg;
	reg [15:0] global_mask_lower_reg;
	reg [15:0] basic_mask_upper_reg;
	reg [15:0] basic_mask_lower_reg;
	reg [15:0] interrupt_enable_reg;
	reg [15:0] interrupt_pending_reg;
	reg [2:0]  prev_state_reg;
	reg        ack_reg;
	reg [7:0]  tq_cnt_reg;
	reg [4:0]  seg_cnt_reg;
	reg [31:0] rd_mux;

	// Diagnostic gate and error interrupt type, both from the config word
	wire diag_features_enable = config_reg[`CTF_CFG_DIAG];
	wire error_irq_type_sel   = config_reg[`CTF_CFG_EIT];

	// Bus decode
	wire req   = wb_cyc_i & wb_stb_i;
	wire hit   = (wb_adr_i == `CTF_OFS_CONFIG)  | (wb_adr_i == `CTF_OFS_TIMING)  |
	             (wb_adr_i == `CTF_OFS_GLOBAL_MASK_WORD_UP) | (wb_adr_i == `CTF_OFS_GLOBAL_MASK_WORD_LO) |
	             (wb_adr_i == `CTF_OFS_BASIC_MASK_WORD_UP) | (wb_adr_i == `CTF_OFS_BASIC_MASK_WORD_LO) |
	             (wb_adr_i == `CTF_OFS_IEN)     | (wb_adr_i == `CTF_OFS_BUFFER_IRQ_PENDING)    |
	             (wb_adr_i == `CTF_OFS_ICLR)    | (wb_adr_i == `CTF_OFS_STATUS);
	// Writes land on the first edge of a request, before ack rises
	wire wr    = req & wb_we_i & ~ack_reg & ce_i;
	wire wr_lo = wr & wb_sel_i[0];
	wire wr_hi = wr & wb_sel_i[1];
	assign wb_ack_o = ack_reg & hit;
	assign wb_err_o = ack_reg & ~hit;

	// Byte-lane merge of a 16-bit register
	function [15:0] merge16;
		input [15:0] old;
		input [15:0] nw;
		input [1:0]  sel;
		begin
			merge16 = {sel[1] ? nw[15:8] : old[15:8], sel[0] ? nw[7:0] : old[7:0]};
		end
	endfunction

	// Mask compare: per bit 0 needs match, 1 is don't care
	function match_bits;
		input [31:0] mask;
		input [31:0] rx;
		input [31:0] bf;
		begin
			match_bits = ~|((rx ^ bf) & ~mask);
		end
	endfunction

	// Overwrite don't-care bits with received values
	function [28:0] merge_id;
		input [28:0] mask;
		input [28:0] rx;
		input [28:0] bf;
		begin
			merge_id = (bf & ~mask) | (rx & mask);
		end
	endfunction

	// Build a {id28..0, srr, ide, rtr} vector for extended frames, {id10..0, 18 zeros, rtr, ide, 0} for standard frames
	function [31:0] frame_vec;
		input [28:0] id;
		input        ide;
		input        srr;
		input        rtr;
		input        ext;
		begin
			if (ext)
				frame_vec = {id, srr, ide, rtr};
			else
				frame_vec = {id[10:0], 18'h0_0000, rtr, ide, 1'b0};
		end
	endfunction

	// Mask words laid out as {m28..18, rtr, ide, m17..0, ext_remote_mask}, vectors as {m28..18, m17..0, rtr, ide, ext_remote_mask}
	wire [31:0] global_mask_word = {global_mask_upper_reg, global_mask_lower_reg};
	wire [31:0] basic_mask_word = {basic_mask_upper_reg, basic_mask_lower_reg};
	wire [31:0] gm_v = {global_mask_word[31:21], global_mask_word[18:1], global_mask_word[20], global_mask_word[19], global_mask_word[0]};
	wire [31:0] bm_v = {basic_mask_word[31:21], basic_mask_word[18:1], basic_mask_word[20], basic_mask_word[19], basic_mask_word[0]};
	// Standard frames ignore the low mask bits and ext_remote_mask
	wire [31:0] std_keep = {11'h7FF, 18'h0_0000, 3'h6};
	wire [31:0] ext_keep = 32'hFFFF_FFFF;
	wire [31:0] keep = rx_ide_i ? ext_keep : std_keep;
	wire [31:0] rx_v = frame_vec(rx_id_i, rx_ide_i, rx_srr_i, rx_rtr_i, rx_ide_i);
	wire [31:0] bf_v = frame_vec(buf_id_i, buf_ide_i, buf_srr_i, buf_rtr_i, rx_ide_i);
	wire [28:0] gm_id = rx_ide_i ? gm_v[31:3] : {18'h0_0000, gm_v[31:21]};
	wire [28:0] bm_id = rx_ide_i ? bm_v[31:3] : {18'h0_0000, bm_v[31:21]};

	// Filter result registers
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			global_accept_o   <= 1'b0;
			basic_accept_o    <= 1'b0;
			global_store_id_o <= 29'h0;
			basic_store_id_o  <= 29'h0;
		end
		else if (ce_i)
		begin
			global_accept_o   <= match_bits(gm_v | ~keep, rx_v, bf_v);
			basic_accept_o    <= match_bits(bm_v | ~keep, rx_v, bf_v);
			global_store_id_o <= merge_id(gm_id, rx_id_i, buf_id_i);
			basic_store_id_o  <= merge_id(bm_id, rx_id_i, buf_id_i);
		end
	end

	// Timing fields
	wire [6:0] prescale_sel      = bit_timing_config_reg[`CTF_TIM_PSC_HI:`CTF_TIM_PSC_LO];
	wire [1:0] resync_jump_width = bit_timing_config_reg[`CTF_TIM_SJW_HI:`CTF_TIM_SJW_LO];
	wire [3:0] phase_segment_one = bit_timing_config_reg[`CTF_TIM_TS1_HI:`CTF_TIM_TS1_LO];
	wire [2:0] phase_segment_two = bit_timing_config_reg[`CTF_TIM_TS2_HI:`CTF_TIM_TS2_LO];
	wire [7:0] psc_sum  = {1'b0, prescale_sel} + `CTF_PSC_ADD;
	wire [7:0] psc_div  = (psc_sum > `CTF_PSC_MAX) ? `CTF_PSC_MAX : psc_sum;
	wire [4:0] ts1_len  = {1'b0, phase_segment_one} + 5'd1;
	wire [4:0] ts2_len  = {2'b00, phase_segment_two} + 5'd1;
	wire [4:0] bit_len  = 5'd1 + ts1_len; // Sync plus first segment ends at sample point
	wire [5:0] total_len = {1'b0, bit_len} + {1'b0, ts2_len};
	// Greater-or-equal end recovers when a smaller prescale is written mid-quantum
	wire       tq_end   = (tq_cnt_reg >= psc_div - 8'd1);

	// Quantum and bit counters
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tq_cnt_reg          <= `CTF_RST8;
			seg_cnt_reg         <= 5'h00;
			tq_tick_o           <= 1'b0;
			sample_point_o      <= 1'b0;
			resync_jump_width_o <= 3'h1;
		end
		else if (ce_i)
		begin
			resync_jump_width_o <= {1'b0, resync_jump_width} + 3'd1;
			tq_tick_o           <= tq_end;
			sample_point_o      <= tq_end & ({1'b0, seg_cnt_reg} == {1'b0, bit_len} - 6'd1);
			if (rx_resync_i)
			begin
				tq_cnt_reg  <= `CTF_RST8;
				seg_cnt_reg <= 5'h00;
			end
			else if (tq_end)
			begin
				tq_cnt_reg <= `CTF_RST8;
				if ({1'b0, seg_cnt_reg} >= total_len - 6'd1)
					seg_cnt_reg <= 5'h00;
				else
					seg_cnt_reg <= seg_cnt_reg + 5'd1;
			end
			else
				tq_cnt_reg <= tq_cnt_reg + 8'd1;
		end
	end

	// Error pending source selection by node state change
	// Passive and bus-off compare only the class bits, bit 0 is free there
	wire state_changed = cnt_incr_i & (node_state_field_i[2:1] != prev_state_reg[2:1] |
	                     (node_state_field_i[2] == 1'b0 &&
	                      node_state_field_i[0] != prev_state_reg[0]));
	wire err_event = error_irq_type_sel ? state_changed : bus_error_i;
	wire [NBUF-1:0] buf_clr = (wr_lo & wr_hi & (wb_adr_i == `CTF_OFS_ICLR)) ?
	                          wb_dat_i[NBUF-1:0] : {NBUF{1'b0}};
	// Error clear needs the high byte lane, buffer clear needs both lanes
	wire err_clr = wr_hi & (wb_adr_i == `CTF_OFS_ICLR) & wb_dat_i[`CTF_ERR_BIT];

	// Register writes, pending flags and ack
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			config_reg            <= `CTF_RST7;
			bit_timing_config_reg <= `CTF_RST16;
			global_mask_upper_reg <= `CTF_RST16;
			global_mask_lower_reg <= `CTF_RST16;
			basic_mask_upper_reg  <= `CTF_RST16;
			basic_mask_lower_reg  <= `CTF_RST16;
			interrupt_enable_reg  <= `CTF_RST16;
			interrupt_pending_reg <= `CTF_RST16;
			prev_state_reg        <= `CTF_NS_IDLE;
			ack_reg               <= 1'b0;
			irq_o                 <= 1'b0;
		end
		else if (ce_i)
		begin
			ack_reg        <= req & ~ack_reg;
			prev_state_reg <= node_state_field_i;
			if (wr && wb_adr_i == `CTF_OFS_CONFIG && wb_sel_i[0])
				config_reg <= wb_dat_i[6:0];
			if (wr && wb_adr_i == `CTF_OFS_TIMING)
				bit_timing_config_reg <= merge16(bit_timing_config_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
			if (wr && wb_adr_i == `CTF_OFS_GLOBAL_MASK_WORD_UP)
				global_mask_upper_reg <= merge16(global_mask_upper_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
			if (wr && wb_adr_i == `CTF_OFS_GLOBAL_MASK_WORD_LO)
				global_mask_lower_reg <= merge16(global_mask_lower_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
			if (wr && wb_adr_i == `CTF_OFS_BASIC_MASK_WORD_UP)
				basic_mask_upper_reg <= merge16(basic_mask_upper_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
			if (wr && wb_adr_i == `CTF_OFS_BASIC_MASK_WORD_LO)
				basic_mask_lower_reg <= merge16(basic_mask_lower_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
			if (wr && wb_adr_i == `CTF_OFS_IEN)
				interrupt_enable_reg <= merge16(interrupt_enable_reg, wb_dat_i[15:0], wb_sel_i[1:0]);
			// Set wins over clear
			interrupt_pending_reg[NBUF-1:0] <= (interrupt_pending_reg[NBUF-1:0] & ~buf_clr) |
			                                   buf_done_i;
			interrupt_pending_reg[`CTF_ERR_BIT] <= (interrupt_pending_reg[`CTF_ERR_BIT] & ~err_clr) |
			                                       err_event;
			// Level request: any pending source whose enable is set
			irq_o <= (interrupt_pending_reg[`CTF_ERR_BIT] & interrupt_enable_reg[`CTF_ERR_BIT]) |
			         |(interrupt_pending_reg[NBUF-1:0] & interrupt_enable_reg[NBUF-1:0]);
		end
	end

	// Diagnostic modes gated by the enable bit
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			listen_only_sel_o <= 1'b0;
			ack_ignore_sel_o  <= 1'b0;
			loopback_sel_o    <= 1'b0;
			internal_sel_o    <= 1'b0;
			hidden_wr_en_o    <= 1'b0;
		end
		else if (ce_i)
		begin
			listen_only_sel_o <= diag_features_enable & config_reg[`CTF_CFG_LISTEN];
			ack_ignore_sel_o  <= diag_features_enable & config_reg[`CTF_CFG_ACKIGN];
			loopback_sel_o    <= diag_features_enable & config_reg[`CTF_CFG_LOOPBACK];
			internal_sel_o    <= diag_features_enable & config_reg[`CTF_CFG_INTERNAL];
			hidden_wr_en_o    <= diag_features_enable & config_reg[`CTF_CFG_HIDDEN_WR];
		end
	end

	// Read mux
	always @*
	begin
		rd_mux = `CTF_RST32;
		case (wb_adr_i)
			`CTF_OFS_CONFIG:  rd_mux = {25'h0, config_reg};
			`CTF_OFS_TIMING:  rd_mux = {16'h0, bit_timing_config_reg};
			`CTF_OFS_GLOBAL_MASK_WORD_UP: rd_mux = {16'h0, global_mask_upper_reg};
			`CTF_OFS_GLOBAL_MASK_WORD_LO: rd_mux = {16'h0, global_mask_lower_reg};
			`CTF_OFS_BASIC_MASK_WORD_UP: rd_mux = {16'h0, basic_mask_upper_reg};
			`CTF_OFS_BASIC_MASK_WORD_LO: rd_mux = {16'h0, basic_mask_lower_reg};
			`CTF_OFS_IEN:     rd_mux = {16'h0, interrupt_enable_reg};
			`CTF_OFS_BUFFER_IRQ_PENDING:    rd_mux = {16'h0, interrupt_pending_reg};
			`CTF_OFS_STATUS:  rd_mux = {29'h0, node_state_field_i};
			default:          rd_mux = `CTF_RST32;
		endcase
	end

	// Read data captured on the taking edge, stands through the ack cycle
	always @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= `CTF_RST32;
		else if (ce_i && req && !ack_reg)
			wb_dat_o <= rd_mux;
	end

endmodule

// [design/ctf_map.vh]
// Register offsets, field positions and reset values of the CAN timing/filter/irq block
`ifndef CTF_MAP_VH
`define CTF_MAP_VH
// Byte offsets on the Wishbone bus
`define CTF_OFS_CONFIG      8'h00
`define CTF_OFS_TIMING      8'h04
`define CTF_OFS_GLOBAL_MASK_WORD_UP     8'h08
`define CTF_OFS_GLOBAL_MASK_WORD_LO     8'h0C
`define CTF_OFS_BASIC_MASK_WORD_UP     8'h10
`define CTF_OFS_BASIC_MASK_WORD_LO     8'h14
`define CTF_OFS_IEN         8'h18
`define CTF_OFS_BUFFER_IRQ_PENDING        8'h1C
`define CTF_OFS_ICLR        8'h20
`define CTF_OFS_STATUS      8'h24
// Config register bit positions
`define CTF_CFG_LISTEN      0
`define CTF_CFG_ACKIGN      1
`define CTF_CFG_LOOPBACK    2
`define CTF_CFG_INTERNAL    3
`define CTF_CFG_HIDDEN_WR   4
`define CTF_CFG_DIAG        5
`define CTF_CFG_EIT         6
// Timing field positions
`define CTF_TIM_PSC_HI      15
`define CTF_TIM_PSC_LO      9
`define CTF_TIM_SJW_HI      8
`define CTF_TIM_SJW_LO      7
`define CTF_TIM_TS1_HI      6
`define CTF_TIM_TS1_LO      3
`define CTF_TIM_TS2_HI      2
`define CTF_TIM_TS2_LO      0
// Pending / enable error bit
`define CTF_ERR_BIT         15
// Reset values
`define CTF_RST16           16'h0000
`define CTF_RST7            7'h00
`define CTF_RST8            8'h00
`define CTF_RST32           32'h0000_0000
// Prescaler saturation value and node-state codes
`define CTF_PSC_MAX         8'h80
`define CTF_PSC_ADD         8'h02
`define CTF_NS_IDLE         3'h0
`define CTF_NS_ACTIVE       3'h2
`define CTF_NS_WARN         3'h3
`endif

// [verif/can_timing_filter_irq_config_test.sv]
// Self-checking bench of ctf_core
module can_timing_filter_irq_config_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [15:0] mu; logic [15:0] ml; logic [3:0] f;
		logic [28:0] id;} ctf_row_t;
	// Filter rows: mask halves, {ide, srr, rtr, accept}, received id
	ctf_row_t rows [8] = '{
		'{16'h0000, 16'h0000, 4'h9, 29'h0AAA_5555},
		'{16'h0000, 16'h0000, 4'h8, 29'h0AAA_5554},
		'{16'h0000, 16'h0002, 4'h9, 29'h0AAA_5554},
		'{16'h0000, 16'h0000, 4'h1, 29'h0AAA_D555},
		'{16'h0020, 16'h0000, 4'h1, 29'h0AAA_5554},
		'{16'h0000, 16'h0001, 4'hB, 29'h0AAA_5555},
		'{16'h0010, 16'h0000, 4'hD, 29'h0AAA_5555},
		'{16'h0000, 16'h0000, 4'hA, 29'h0AAA_5555}};
	logic [15:0] tw [4] = '{16'h007F, 16'hFCFF, 16'hFF1B, 16'h07AC};
	logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0, rx_ide_i = 1'b0, rx_srr_i = 1'b0, rx_rtr_i = 1'b0, rx_resync_i = 1'b0;
	logic buf_ide_i = 1'b0, buf_srr_i = 1'b0, buf_rtr_i = 1'b0, e;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q;
	logic [28:0] rx_id_i = 29'h0000_0000, buf_id_i = 29'h0AAA_5555;
	logic [28:0] global_store_id_o, basic_store_id_o;
	logic [2:0]  resync_jump_width_o, node_state_field_i;
	logic [14:0] buf_done_i;
	logic wb_ack_o, wb_err_o, global_accept_o, basic_accept_o, listen_only_sel_o, irq_o;
	logic ack_ignore_sel_o, loopback_sel_o, internal_sel_o, hidden_wr_en_o, tq_tick_o;
	logic sample_point_o, bus_error_i, cnt_incr_i;
	wire [4:0] diag = {hidden_wr_en_o, internal_sel_o, loopback_sel_o, ack_ignore_sel_o,
		listen_only_sel_o};
	int err_count = 0, checks = 0, cyc_cnt = 0, g, p;
	ctf_core uut
	(
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
		.bus_error_i(bus_error_i), .node_state_field_i(node_state_field_i),
		.cnt_incr_i(cnt_incr_i), .buf_done_i(buf_done_i), .rx_id_i(rx_id_i),
		.rx_ide_i(rx_ide_i), .rx_srr_i(rx_srr_i), .rx_rtr_i(rx_rtr_i), .buf_id_i(buf_id_i),
		.buf_ide_i(buf_ide_i), .buf_srr_i(buf_srr_i), .buf_rtr_i(buf_rtr_i),
		.rx_resync_i(rx_resync_i), .global_accept_o(global_accept_o),
		.basic_accept_o(basic_accept_o), .global_store_id_o(global_store_id_o),
		.basic_store_id_o(basic_store_id_o), .listen_only_sel_o(listen_only_sel_o),
		.ack_ignore_sel_o(ack_ignore_sel_o), .loopback_sel_o(loopback_sel_o),
		.internal_sel_o(internal_sel_o), .hidden_wr_en_o(hidden_wr_en_o),
		.tq_tick_o(tq_tick_o), .sample_point_o(sample_point_o),
		.resync_jump_width_o(resync_jump_width_o), .irq_o(irq_o)
	);
	ctf_far_side far
	(
		.clk_i(clk_i), .bus_err_o(bus_error_i), .incr_o(cnt_incr_i),
		.ns_o(node_state_field_i), .done_o(buf_done_i)
	);
	always #2 clk_i = ~clk_i;
	// Hang guard
	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (cyc_cnt == 30000)
		begin
			err_count++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		if (err_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] x);
		checks++;
		if (got !== x)
		begin
			err_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, x);
		end
	endtask
	// Classic cycle held until ack or err
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
		q = wb_dat_o;
		e = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		wb(1'b0, a, 32'h0000_0000);
		chk(q, x);
	endtask
	// Second gap between pulses of tick (s=0) or sample point (s=1)
	task automatic gap(input logic s);
		for (int k = 0; k < 3; k++)
		begin
			g = 0;
			do
			begin
				@(posedge clk_i);
				g++;
			end
			while ((s ? sample_point_o : tq_tick_o) !== 1'b1 && g < 4000);
		end
	endtask
	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i])
		begin
			wb(1'b1, 8'h08, {16'h0000, rows[i].mu});
			wb(1'b1, 8'h0C, {16'h0000, rows[i].ml});
			wb(1'b1, 8'h10, {16'h0000, rows[i].mu});
			wb(1'b1, 8'h14, {16'h0000, rows[i].ml});
			rx_id_i <= rows[i].id;
			{rx_ide_i, rx_srr_i, rx_rtr_i} <= rows[i].f[3:1];
			buf_ide_i <= rows[i].f[3];
			repeat (2) @(posedge clk_i);
			chk({31'h0, global_accept_o}, {31'h0, rows[i].f[0]});
			chk({31'h0, basic_accept_o}, {31'h0, rows[i].f[0]});
			// Accepted extended frame: stored id equals the received id
			if (rows[i].f[3] & rows[i].f[0])
			begin
				chk({3'h0, global_store_id_o}, {3'h0, rows[i].id});
				chk({3'h0, basic_store_id_o}, {3'h0, rows[i].id});
			end
		end
		for (int i = 0; i < 8; i++)
		begin
			rst_i <= (i == 0);
			@(posedge clk_i);
			rst_i <= 1'b0;
			rdc(8'(4 * i), 32'h0000_0000);
		end
		for (int i = 1; i < 8; i++)
		begin
			wb(1'b1, 8'(4 * i), 32'hFFFF_FFFF);
			rdc(8'(4 * i), (i == 7) ? 32'h0000_0000 : 32'h0000_FFFF);
		end
		rdc(8'h20, 32'h0000_0000);
		wb(1'b0, 8'h28, 32'h0000_0000);
		chk({31'h0, e}, 32'h0000_0001);
		for (int d = 0; d < 2; d++)
		begin
			wb(1'b1, 8'h00, d ? 32'h0000_003F : 32'h0000_001F);
			repeat (2) @(posedge clk_i);
			chk({27'h0, diag}, d ? 32'h0000_001F : 32'h0000_0000);
		end
		foreach (tw[i])
		begin
			wb(1'b1, 8'h04, {16'h0000, tw[i]});
			repeat (2) @(posedge clk_i);
			chk({29'h0, resync_jump_width_o}, {30'h0, tw[i][8:7]} + 32'h1);
			rx_resync_i <= 1'b1;
			@(posedge clk_i);
			rx_resync_i <= 1'b0;
			p = (tw[i][15:9] == 7'h7F) ? 128 : tw[i][15:9] + 2;
			gap(1'b0);
			chk(g, p);
			gap(1'b1);
			chk(g, p * (3 + tw[i][6:3] + tw[i][2:0]));
		end
		wb(1'b1, 8'h00, 32'h0000_0000);
		wb(1'b1, 8'h18, 32'h0000_8000);
		far.pulse_err();
		rdc(8'h1C, 32'h0000_8000);
		chk({31'h0, irq_o}, 32'h0000_0001);
		wb(1'b1, 8'h20, 32'h0000_7FFF);
		rdc(8'h1C, 32'h0000_8000);
		wb(1'b1, 8'h18, 32'h0000_0000);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0000_0000);
		wb(1'b1, 8'h20, 32'h0000_8000);
		rdc(8'h1C, 32'h0000_0000);
		// Frozen while the clock enable is low
		ce_i <= 1'b0;
		far.pulse_err();
		ce_i <= 1'b1;
		rdc(8'h1C, 32'h0000_0000);
		wb(1'b1, 8'h00, 32'h0000_0040);
		far.pulse_err();
		rdc(8'h1C, 32'h0000_0000);
		far.step(3'h3);
		rdc(8'h1C, 32'h0000_8000);
		wb(1'b1, 8'h20, 32'h0000_8000);
		far.step(3'h4);
		wb(1'b1, 8'h20, 32'h0000_8000);
		far.step(3'h5);
		rdc(8'h1C, 32'h0000_0000);
		far.step(3'h6);
		rdc(8'h1C, 32'h0000_8000);
		rdc(8'h24, 32'h0000_0006);
		for (int n = 0; n < 15; n++)
		begin
			wb(1'b1, 8'h18, 32'h0000_0001 << n);
			far.done(n);
			rdc(8'h1C, 32'h0000_8000 | (32'h0000_0001 << n));
			chk({31'h0, irq_o}, 32'h0000_0001);
			wb(1'b1, 8'h20, 32'h0000_0001 << n);
			rdc(8'h1C, 32'h0000_8000);
		end
		end_of_test();
	end
endmodule

// [verif/ctf_core_asserts.sv]
// Checker on the bus, diagnostic and bit timing ports of ctf_core
module ctf_core_asserts
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic        wb_err_o,
	input wire logic        listen_only_sel_o,
	input wire logic        ack_ignore_sel_o,
	input wire logic        loopback_sel_o,
	input wire logic        internal_sel_o,
	input wire logic        hidden_wr_en_o,
	input wire logic        tq_tick_o,
	input wire logic [2:0]  resync_jump_width_o,
	input wire logic        irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Diagnostic outputs in config bit order, write data fields
	wire [4:0] diag = {hidden_wr_en_o, internal_sel_o, loopback_sel_o, ack_ignore_sel_o,
		listen_only_sel_o};
	wire [4:0] cfg_f = wb_dat_i[4:0];
	wire [1:0] sjw_f = wb_dat_i[8:7];
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// First cycle of a request, then config and timing writes
	sequence wb_req;
		wb_cyc_i && wb_stb_i && ce_i && !wb_ack_o && !wb_err_o;
	endsequence
	sequence cfg_wr;
		wb_req ##0 (wb_we_i && wb_adr_i == 8'h00 && wb_sel_i[0]);
	endsequence
	sequence tim_wr;
		wb_req ##0 (wb_we_i && wb_adr_i == 8'h04 && wb_sel_i[1:0] == 2'b11);
	endsequence
	ack_timely_a: assert property (wb_req |=> wb_ack_o != wb_err_o)
		else $error("Request not answered next cycle");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("Ack longer than one cycle");
	err_mapped_a: assert property (wb_req ##0 (wb_adr_i <= 8'h24 && wb_adr_i[1:0] == 2'b00)
		|=> !wb_err_o) else $error("Error on mapped address");
	diag_gate_a: assert property (cfg_wr ##0 !wb_dat_i[5] |-> ##2 diag == 5'h00)
		else $error("Diagnostic mode active while gated");
	diag_pass_a: assert property (cfg_wr ##0 wb_dat_i[5] |-> ##2 diag == $past(cfg_f, 2))
		else $error("Diagnostic mode not taken");
	sjw_map_a: assert property (tim_wr |-> ##2
		resync_jump_width_o == {1'b0, $past(sjw_f, 2)} + 3'h1)
		else $error("Jump width wrong");
	tick_pulse_a: assert property (tq_tick_o && ce_i |=> !tq_tick_o)
		else $error("Quantum shorter than two clocks");
	reset_vals_a: assert property ($fell(rst_i) |->
		!irq_o && diag == 5'h00 && resync_jump_width_o == 3'h1)
		else $error("Bad value after reset");
endmodule

bind ctf_core ctf_core_asserts chk_u
(
	.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .listen_only_sel_o(listen_only_sel_o),
	.ack_ignore_sel_o(ack_ignore_sel_o), .loopback_sel_o(loopback_sel_o),
	.internal_sel_o(internal_sel_o), .hidden_wr_en_o(hidden_wr_en_o), .tq_tick_o(tq_tick_o),
	.resync_jump_width_o(resync_jump_width_o), .irq_o(irq_o)
);

// [verif/ctf_far_side.sv]
// Far side model: bus errors, error counter steps, buffer completions
module ctf_far_side
(
	input  wire logic   clk_i,
	output logic        bus_err_o,
	output logic        incr_o,
	output logic [2:0]  ns_o,
	output logic [14:0] done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle, node error active
	initial
	begin
		bus_err_o = 1'b0;
		incr_o = 1'b0;
		ns_o = 3'h2;
		done_o = 15'h0000;
	end
	// One-cycle bus error
	task automatic pulse_err();
		@(posedge clk_i);
		bus_err_o <= 1'b1;
		@(posedge clk_i);
		bus_err_o <= 1'b0;
	endtask
	// Counter increment landing in node state ns
	task automatic step(input logic [2:0] ns);
		@(posedge clk_i);
		ns_o <= ns;
		incr_o <= 1'b1;
		@(posedge clk_i);
		incr_o <= 1'b0;
	endtask
	// Successful transfer through buffer n
	task automatic done(input int n);
		@(posedge clk_i);
		done_o <= 15'h0001 << n;
		@(posedge clk_i);
		done_o <= 15'h0000;
	endtask
endmodule
